// [tlbinv_pkg.sv]
/*
 * Package for the translation cache invalidate register block.
 * Holds register offsets, field positions, widths and invalidate kind codes.
 * Assumes a 32-bit register port and a translation cache that takes one
 * invalidate request per cycle without back-pressure.
 */
package tlbinv_pkg;

    // Register word offsets on the 32-bit register port.
    localparam logic [7:0] SEC_MON_VA_LO_OFFS  = 8'h00;
    localparam logic [7:0] SEC_MON_VA_HI_OFFS  = 8'h04;
    localparam logic [7:0] HOST_VA_NARROW_OFFS = 8'h08;
    localparam logic [7:0] HOST_VA_WIDE_LO_OFFS = 8'h10;
    localparam logic [7:0] HOST_VA_WIDE_HI_OFFS = 8'h14;
    localparam logic [7:0] HOST_VA_LAST_LO_OFFS = 8'h18;
    localparam logic [7:0] HOST_VA_LAST_HI_OFFS = 8'h1c;
    localparam logic [7:0] GUEST_TAG_OFFS      = 8'h20;
    localparam logic [7:0] GUEST_TAG_S1_OFFS   = 8'h24;
    localparam logic [7:0] CONFIG_OFFS         = 8'h40;
    localparam logic [7:0] STATUS_OFFS         = 8'h44;

    // Field positions.
    localparam int WIDE_ADDR_MSB    = 43;
    localparam int NARROW_ADDR_LSB  = 12;
    localparam int GUEST_TAG_MSB    = 15;
    localparam int GUEST_TAG_NARROW_MSB = 7;
    localparam int CFG_SECURE_BIT   = 0;
    localparam int CFG_NARROW_BIT   = 1;
    localparam int CFG_WIDETAG_BIT  = 2;
    localparam int CFG_NESTED_BIT   = 3;
    localparam int CFG_GRAN_LSB     = 4;

    // Reset values.
    localparam logic [31:0] CONFIG_RESET = 32'h0000_000f;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;

    // Translation granule codes held in the configuration register.
    localparam logic [1:0] GRAN_4K  = 2'h0;
    localparam logic [1:0] GRAN_16K = 2'h1;
    localparam logic [1:0] GRAN_64K = 2'h2;

    typedef enum logic [2:0] {
        TLBINV_NONE,
        TLBINV_MON_VA,
        TLBINV_HOST_VA,
        TLBINV_HOST_VA_LAST,
        TLBINV_GUEST_TAG,
        TLBINV_GUEST_TAG_S1
    } tlbinv_kind_t;

endpackage

// [tlbinv_regs.sv]
/*
 * Write-only translation cache invalidate registers.
 * Each accepted write to an invalidate register launches one request, one cycle long, to the
 * translation cache. Assumes the cache never discards locked entries and may
 * over-invalidate unlocked ones; it honours the match fields sent here.
 */
// The register addresses and strobed register access are this design's own decisions.
// Summary of operation
// - Monitor address invalidate removes unlocked monitor-context entries matching the address.
// - Sixty-four bit registers take low word zero-extended; high word writes are dropped.
// - Over-invalidation of unlocked entries allowed; locked entries are never discarded.
// - With one security state, monitor address register reads zero, ignores writes.
// - Wide address registers carry address bits 55:12 in bits 43:0; only bits 31:0 are taken, giving address bits 43:12.
// - With 64KB granule, address bits 15:12 are ignored for matching.
// - With 16KB granule, address bits 13:12 are ignored for matching.
// - Narrow host register takes address bits 31:12 from bits 31:12.
// - Host address invalidate removes unlocked host entries for that address.
// - Without 32-bit schemes, narrow host register reads zero, ignores writes.
// - Wide host address extends bit 55 up through bit 63.
// - For 32-bit scheme entries, address bits 55:32 are treated as zero.
// - Last-level host invalidate removes only matching final-level host entries.
// - Tag invalidate removes unlocked non-secure, non-host entries carrying the tag.
// - Tag invalidates never touch secure entries.
// - Tag sits in bits 15:0; bits 15:8 reserved without wide tag support.
// - Stage-one tag invalidate removes stage-one entries, or all tagged when nested.
`timescale 1ns/100ps
module tlbinv_regs (
    // Clock, reset and enable.
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // Register port.
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [31:0] regRdData,
    // Invalidate request toward the translation cache.
    output logic             invValid,
    output logic      [2:0]  invKind,
    output logic      [63:0] invAddr,
    output logic      [63:0] invAddrMask,
    output logic             invNarrowScheme,
    output logic      [15:0] invTag,
    output logic             invMonitorOnly,
    output logic             invHostOnly,
    output logic             invNonSecureOnly,
    output logic             invLastLevelOnly,
    output logic             invStageOneOnly,
    output logic             invKeepLocked
);

    typedef struct packed {
        logic [31:0] cfgReg;
        logic [15:0] count;
        logic [31:0] rdData;
        logic        valid;
        logic [2:0]  kind;
        logic [63:0] addr;
        logic [63:0] mask;
        logic        narrow;
        logic [15:0] tag;
    } tlbinv_state_t;

    tlbinv_state_t state;
    tlbinv_state_t next_state;

    logic secureSupport;
    logic narrowSupport;
    logic wideTagSupport;
    logic nestedSupport;
    logic [1:0] granule;

    assign secureSupport  = state.cfgReg[tlbinv_pkg::CFG_SECURE_BIT];
    assign narrowSupport  = state.cfgReg[tlbinv_pkg::CFG_NARROW_BIT];
    assign wideTagSupport = state.cfgReg[tlbinv_pkg::CFG_WIDETAG_BIT];
    assign nestedSupport  = state.cfgReg[tlbinv_pkg::CFG_NESTED_BIT];
    assign granule        = state.cfgReg[tlbinv_pkg::CFG_GRAN_LSB +: 2];

    // Builds a full address from the wide register layout with sign extension.
    function automatic logic [63:0] wideAddr(input logic [31:0] lo);
        logic [55:0] a;
        a = {12'h000, lo, 12'h000};
        wideAddr = {{8{a[55]}}, a};
    endfunction

    // Mask of address bits that take part in matching for the granule.
    function automatic logic [63:0] granMask(input logic [1:0] g);
        granMask = 64'hffff_ffff_ffff_f000;
        if (g == tlbinv_pkg::GRAN_64K) begin
            granMask[15:12] = 4'h0;
        end else if (g == tlbinv_pkg::GRAN_16K) begin
            granMask[13:12] = 2'h0;
        end
    endfunction

    always_comb begin
        next_state = state;
        next_state.valid = 1'b0;
        next_state.kind = tlbinv_pkg::TLBINV_NONE;
        if (regWrEn) begin
            case (regAddr)
                tlbinv_pkg::SEC_MON_VA_LO_OFFS: begin
                    if (secureSupport) begin
                        next_state.valid = 1'b1;
                        next_state.kind = tlbinv_pkg::TLBINV_MON_VA;
                        next_state.addr = wideAddr(regWrData);
                        next_state.mask = granMask(granule);
                        next_state.narrow = 1'b0;
                    end
                end
                tlbinv_pkg::HOST_VA_NARROW_OFFS: begin
                    if (narrowSupport) begin
                        next_state.valid = 1'b1;
                        next_state.kind = tlbinv_pkg::TLBINV_HOST_VA;
                        next_state.addr = {32'h0000_0000, regWrData[31:12], 12'h000};
                        next_state.mask = granMask(granule);
                        next_state.narrow = 1'b1;
                    end
                end
                tlbinv_pkg::HOST_VA_WIDE_LO_OFFS,
                tlbinv_pkg::HOST_VA_LAST_LO_OFFS: begin
                    next_state.valid = 1'b1;
                    next_state.kind = (regAddr == tlbinv_pkg::HOST_VA_LAST_LO_OFFS)
                        ? tlbinv_pkg::TLBINV_HOST_VA_LAST : tlbinv_pkg::TLBINV_HOST_VA;
                    next_state.addr = wideAddr(regWrData);
                    next_state.mask = granMask(granule);
                    next_state.narrow = 1'b0;
                end
                tlbinv_pkg::GUEST_TAG_OFFS,
                tlbinv_pkg::GUEST_TAG_S1_OFFS: begin
                    next_state.valid = 1'b1;
                    next_state.kind = (regAddr == tlbinv_pkg::GUEST_TAG_S1_OFFS)
                        ? tlbinv_pkg::TLBINV_GUEST_TAG_S1 : tlbinv_pkg::TLBINV_GUEST_TAG;
                    next_state.tag = regWrData[15:0];
                    if (!wideTagSupport) begin
                        next_state.tag[15:8] = 8'h00;
                    end
                end
                tlbinv_pkg::CONFIG_OFFS: begin
                    next_state.cfgReg = regWrData;
                end
                default: begin
                    // High-word writes and unmapped addresses are dropped.
                end
            endcase
            if (next_state.valid) begin
                next_state.count = state.count + 16'h0001;
            end
        end
        next_state.rdData = 32'h0000_0000;
        if (regRdEn) begin
            case (regAddr)
                tlbinv_pkg::CONFIG_OFFS: next_state.rdData = state.cfgReg;
                tlbinv_pkg::STATUS_OFFS: next_state.rdData = {16'h0000, state.count};
                default: next_state.rdData = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= '0;
            state.cfgReg <= tlbinv_pkg::CONFIG_RESET;
            state.count <= tlbinv_pkg::COUNT_RESET;
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    assign regRdData       = state.rdData;
    assign invValid        = state.valid;
    assign invKind         = state.kind;
    assign invAddr         = state.addr;
    assign invAddrMask     = state.mask;
    assign invNarrowScheme = state.narrow;
    assign invTag          = state.tag;
    assign invMonitorOnly  = (state.kind == tlbinv_pkg::TLBINV_MON_VA);
    assign invHostOnly     = (state.kind == tlbinv_pkg::TLBINV_HOST_VA)
                           || (state.kind == tlbinv_pkg::TLBINV_HOST_VA_LAST);
    assign invNonSecureOnly = (state.kind == tlbinv_pkg::TLBINV_GUEST_TAG)
                           || (state.kind == tlbinv_pkg::TLBINV_GUEST_TAG_S1);
    assign invLastLevelOnly = (state.kind == tlbinv_pkg::TLBINV_HOST_VA_LAST);
    assign invStageOneOnly  = (state.kind == tlbinv_pkg::TLBINV_GUEST_TAG_S1) && !nestedSupport;
    assign invKeepLocked    = 1'b1;

    a_write_launch: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && regWrEn && regAddr == tlbinv_pkg::GUEST_TAG_OFFS |=> invValid)
        else $error("tag write did not launch invalidate");
    a_high_drop: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && regWrEn && regAddr == tlbinv_pkg::HOST_VA_WIDE_HI_OFFS |=> !invValid)
        else $error("high word write launched invalidate");
    a_mon_gate: assert property (@(posedge core_clk) disable iff (rst)
        invMonitorOnly && invValid |-> $past(secureSupport))
        else $error("monitor invalidate without secure support");
    a_narrow_gate: assert property (@(posedge core_clk) disable iff (rst)
        invValid && invNarrowScheme |-> $past(narrowSupport))
        else $error("narrow invalidate without support");
    a_sign_extend: assert property (@(posedge core_clk) disable iff (rst)
        invValid && !invNarrowScheme && invHostOnly |-> invAddr[63:56] == {8{invAddr[55]}})
        else $error("address not extended");
    a_narrow_upper: assert property (@(posedge core_clk) disable iff (rst)
        invValid && invNarrowScheme |-> invAddr[63:32] == 32'h0000_0000)
        else $error("narrow address upper bits set");
    a_gran_64k: assert property (@(posedge core_clk) disable iff (rst)
        invValid && (invHostOnly || invMonitorOnly) && $past(granule) == tlbinv_pkg::GRAN_64K
        |-> invAddrMask[15:12] == 4'h0)
        else $error("64KB granule bits not ignored");
    a_tag_narrow: assert property (@(posedge core_clk) disable iff (rst)
        invValid && invNonSecureOnly && !$past(wideTagSupport) |-> invTag[15:8] == 8'h00)
        else $error("reserved tag bits passed");
    a_read_zero: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && regRdEn && regAddr == tlbinv_pkg::GUEST_TAG_OFFS |=> regRdData == 32'h0000_0000)
        else $error("write-only register read nonzero");

endmodule

// [tb_tlbinv_regs.sv]
/*
 * Self-checking testbench for the translation cache invalidate registers.
 * Assumes the design's package is compiled first; the bench drives the port itself.
 */
`timescale 1ns/100ps
module tb_tlbinv_regs;
    logic        core_clk;
    logic        rst;
    logic        clkEn;
    logic [7:0]  regAddr;
    logic [31:0] regWrData;
    logic        regWrEn;
    logic        regRdEn;
    logic [31:0] regRdData;
    logic        invValid;
    logic [2:0]  invKind;
    logic [63:0] invAddr;
    logic [63:0] invAddrMask;
    logic        invNarrowScheme;
    logic [15:0] invTag;
    logic        invMonitorOnly;
    logic        invHostOnly;
    logic        invNonSecureOnly;
    logic        invLastLevelOnly;
    logic        invStageOneOnly;
    logic        invKeepLocked;
    int          numErrors = 0;
    int          cmpCount  = 0;
    int          cycles    = 0;
    logic [15:0] expCount  = 16'h0000;
    logic [31:0] rd;

    tlbinv_regs u_dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .invValid(invValid), .invKind(invKind), .invAddr(invAddr), .invAddrMask(invAddrMask),
        .invNarrowScheme(invNarrowScheme), .invTag(invTag), .invMonitorOnly(invMonitorOnly),
        .invHostOnly(invHostOnly), .invNonSecureOnly(invNonSecureOnly),
        .invLastLevelOnly(invLastLevelOnly), .invStageOneOnly(invStageOneOnly),
        .invKeepLocked(invKeepLocked));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run of under a hundred cycles.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            complete_run();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmpCount++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            numErrors++;
        end
    endtask

    // One-cycle write; the launched request is checked in the cycle after the strobe.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic v,
                      input logic [2:0] k);
        @(posedge core_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        #1;
        chk({63'h0, invValid}, {63'h0, v});
        if (v) begin
            chk({61'h0, invKind}, {61'h0, k});
            chk({63'h0, invKeepLocked}, 64'h1);
            expCount++;
        end
    endtask

    task automatic rdReg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        chk({32'h0, regRdData}, {32'h0, exp});
    endtask

    task automatic endTest(input string name);
        $display("Test %s finished, mismatches so far %0d", name, numErrors);
    endtask

    initial begin
        rst = 1'b1; clkEn = 1'b1; regAddr = 8'h00; regWrData = 32'h0;
        regWrEn = 1'b0; regRdEn = 1'b0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rdReg(tlbinv_pkg::CONFIG_OFFS, tlbinv_pkg::CONFIG_RESET);
        rdReg(tlbinv_pkg::STATUS_OFFS, 32'h0);
        endTest("reset");
        wr(8'h00, 32'hfedcb123, 1'b1, 3'h1);
        chk(invAddr, 64'h0000_0fed_cb12_3000);
        chk(invAddrMask, 64'hffff_ffff_ffff_f000);
        chk({63'h0, invMonitorOnly}, 64'h1);
        wr(8'h04, 32'hffffffff, 1'b0, 3'h0);
        wr(8'h14, 32'hffffffff, 1'b0, 3'h0);
        wr(8'h1c, 32'hffffffff, 1'b0, 3'h0);
        wr(8'h30, 32'hffffffff, 1'b0, 3'h0);
        chk(invAddr, 64'h0000_0fed_cb12_3000);
        endTest("monitor");
        wr(8'h08, 32'h89abcfff, 1'b1, 3'h2);
        chk(invAddr, 64'h0000_0000_89ab_c000);
        chk({62'h0, invNarrowScheme, invHostOnly}, 64'h3);
        wr(8'h10, 32'h12345678, 1'b1, 3'h2);
        chk(invAddr, 64'h0000_0123_4567_8000);
        chk({62'h0, invNarrowScheme, invHostOnly}, 64'h1);
        wr(8'h18, 32'h000abcde, 1'b1, 3'h3);
        chk(invAddr, 64'h0000_0000_abcd_e000);
        chk({62'h0, invLastLevelOnly, invHostOnly}, 64'h3);
        endTest("host");
        wr(8'h20, 32'habcd1234, 1'b1, 3'h4);
        chk({48'h0, invTag}, 64'h1234);
        chk({63'h0, invNonSecureOnly}, 64'h1);
        wr(8'h24, 32'h0000beef, 1'b1, 3'h5);
        chk({62'h0, invNonSecureOnly, invStageOneOnly}, 64'h2);
        endTest("tag");
        wr(tlbinv_pkg::CONFIG_OFFS, 32'h00000017, 1'b0, 3'h0);
        rdReg(tlbinv_pkg::CONFIG_OFFS, 32'h00000017);
        wr(8'h10, 32'h0000ffff, 1'b1, 3'h2);
        chk(invAddrMask, 64'hffff_ffff_ffff_c000);
        wr(8'h24, 32'h00005a5a, 1'b1, 3'h5);
        chk({63'h0, invStageOneOnly}, 64'h1);
        wr(tlbinv_pkg::CONFIG_OFFS, 32'h00000027, 1'b0, 3'h0);
        wr(8'h00, 32'h0000ffff, 1'b1, 3'h1);
        chk(invAddrMask, 64'hffff_ffff_ffff_0000);
        endTest("granule");
        wr(tlbinv_pkg::CONFIG_OFFS, 32'h00000020, 1'b0, 3'h0);
        wr(8'h00, 32'h00001111, 1'b0, 3'h0);
        wr(8'h08, 32'h00002000, 1'b0, 3'h0);
        wr(8'h20, 32'h00001234, 1'b1, 3'h4);
        chk({48'h0, invTag}, 64'h0034);
        rdReg(8'h00, 32'h0);
        rdReg(8'h08, 32'h0);
        rdReg(8'h10, 32'h0);
        rdReg(8'h20, 32'h0);
        // A write while the clock enable is low must be ignored entirely.
        @(posedge core_clk);
        clkEn     <= 1'b0;
        regAddr   <= 8'h20;
        regWrData <= 32'h00000055;
        regWrEn   <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        clkEn   <= 1'b1;
        #1;
        chk({63'h0, invValid}, 64'h0);
        rdReg(tlbinv_pkg::STATUS_OFFS, {16'h0, expCount});
        endTest("config");
        complete_run();
    end
endmodule
